// ---- src/hmtf_regs.v ----
// hmtf_regs.v: thermal/fan register bank of a hardware monitor
// assumes: host drives index/data strobes synchronous to CORE_CLK;
// readings and limit events come from converter logic outside
//
// What this block does
// R1: diode-mode bits pick cpu-compatible thermal diode
// R2: bank0 5Dh bits 6,5 give divisor bit 2
// R3: sensor-type bits pick diode or thermistor
// R4: battery reading valid one monitor cycle after enable
// R5: critical protection enables, both off at reset
// R6: current-mode bits override type and diode settings
// R7: auto mode raises cpu drive up to maximum
// R8: software keeps maximum nonzero and above stop
// R9: auto adjustments move cpu drive by step
// R10: in target mode, critical temperature exceeded forces drive full
// R11: nine-bit temperature split high byte, low bit7
// R12: bank2 reading follows sys source select; bank1 always shows cpu reading
// R13: fault count filters overtemp output trips
// R14: overtemp mode bit: comparator or interrupt
// R15: halt bit stops cpu channel monitoring
// R16: hysteresis threshold nine bits, reset 75C
// R17: overtemp limit nine bits, reset 80C
// R18: status bits set on battery/standby limit
// R19: mask bits block status from irq
// R20: software writes zero to reserved config bits
// R21: bank number selects registers at 50h-5Fh
// R22: divisor bits 1,0 live in register 47h
// R23: channel status sets over limit, clears below hyst
// R24: irq asserted while unmasked status is set
`timescale 1ns/10ps
`include "hmtf_consts.vh"

module hmtf_regs #(
  parameter ADJ_NS = `HMTF_FAN_ADJ_NS
) (
  // clock and reset
  input wire CORE_CLK,
  input wire RST,
  // index/data register port
  input wire [6:0] REG_INDEX,
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_WDATA,
  output reg [7:0] REG_RDATA,
  // converter readings (nine bits, half-degree units)
  input wire [8:0] CPU_TEMP_IN,
  input wire [8:0] SYS_TEMP_IN,
  input wire CONV_DONE,
  input wire BAT_LIMIT_EVT,
  input wire SB_LIMIT_EVT,
  // fan control mode and source selects from other banks
  input wire AUTO3_MODE,
  input wire TARGET_MODE,
  input wire FAN_TEMP_HOT,
  input wire [2:0] CPU_SRC_SEL,
  input wire [2:0] SYS_SRC_SEL,
  // sensing configuration to the analog front end
  output reg [1:0] CPU_SENSE_MODE,
  output reg [1:0] SYS_SENSE_MODE,
  output reg [2:0] CPU_TACH_DIV,
  output reg [2:0] SYS_TACH_DIV,
  output reg BAT_MON_ON,
  output reg CPU_MON_ON,
  // drives and alarms
  output reg [7:0] CPU_FAN_DRIVE,
  output reg SYS_FAN_FULL,
  output reg OVERTEMP_OUT,
  output reg CPU_TEMP_STS,
  output reg SYSTEM_MGMT_IRQ
);

  // ****************************************
  // derived timing
  // ****************************************
  localparam [31:0] ADJ_CYC = (ADJ_NS / `HMTF_CLK_NS) < 1 ? 1 :
                              (ADJ_NS / `HMTF_CLK_NS);
  // mask reset word; reserved bits read back as their reset value
  localparam [7:0] RST_MASK = `HMTF_RST_IRQ_MASK;
  // sense mode codes: thermistor, diode, current
  localparam [1:0] SENSE_THERM = 2'h0;
  localparam [1:0] SENSE_DIODE = 2'h1;
  localparam [1:0] SENSE_CURR = 2'h2;

  // ****************************************
  // storage
  // ****************************************
  reg [7:0] bank_sel_reg; // bank select, 3 low bits used
  reg [7:0] fan_div1_reg; // divisor bits 1,0
  reg [7:0] diode_sel_reg;
  reg [7:0] bat_ctrl_reg;
  reg [7:0] crit_en_reg;
  reg [7:0] fan_max_reg;
  reg [7:0] fan_step_reg;
  reg [7:0] sys_crit_reg;
  reg [7:0] cpu_crit_reg;
  reg [7:0] cfg_reg;
  reg [8:0] hyst_reg;
  reg [8:0] ovt_reg;
  reg [8:0] cpu_temp_reg; // latest cpu reading
  reg [8:0] sys_temp_reg; // latest sys reading
  reg [1:0] irq_sts_reg; // sticky battery/standby status
  reg [1:0] irq_mask_reg;
  reg [1:0] fault_cnt_reg; // consecutive over-limit samples
  reg bat_en_d_reg; // previous enable for edge detect
  reg bat_wait_reg; // waiting one monitor cycle
  reg [15:0] adj_cnt_reg; // fan adjustment tick divider
  wire [2:0] bank = bank_sel_reg[2:0];
  wire in_win = (REG_INDEX >= `HMTF_BANK_WIN_LO) &&
                (REG_INDEX <= `HMTF_BANK_WIN_HI);
  wire adj_tick = (adj_cnt_reg == 16'h0000);
  // bank1 reading is always the cpu reading; CPU_SRC_SEL is not used
  wire [8:0] bank1_temp = cpu_temp_reg; // R12
  // bank2 reading: code 1 picks cpu, else sys
  wire [8:0] bank2_temp = (SYS_SRC_SEL == 3'h1) ? cpu_temp_reg :
                          sys_temp_reg; // R12
  wire cpu_over = cpu_temp_reg > ovt_reg;
  wire cpu_under = cpu_temp_reg < hyst_reg;
  // the reading being latched now, for the fault filter
  wire new_over = CPU_TEMP_IN > ovt_reg;
  wire new_under = CPU_TEMP_IN < hyst_reg;
  wire [8:0] fan_sum = {1'b0, CPU_FAN_DRIVE} + {1'b0, fan_step_reg};

  // ****************************************
  // register writes
  // ****************************************
  // host writes; bank window decoded by bank number
  always @(posedge CORE_CLK) begin
    if (RST) begin
      bank_sel_reg <= `HMTF_RST_BANK_SEL;
      fan_div1_reg <= `HMTF_RST_FAN_DIV1;
      diode_sel_reg <= `HMTF_RST_DIODE_SEL;
      bat_ctrl_reg <= `HMTF_RST_BAT_CTRL;
      crit_en_reg <= `HMTF_RST_CRIT_EN; // R5
      fan_max_reg <= `HMTF_RST_FAN_MAX;
      fan_step_reg <= `HMTF_RST_FAN_STEP;
      sys_crit_reg <= `HMTF_RST_CRIT_TEMP;
      cpu_crit_reg <= `HMTF_RST_CRIT_TEMP;
      cfg_reg <= `HMTF_RST_CFG;
      hyst_reg <= {`HMTF_RST_HYST_HI, 1'b0}; // R16
      ovt_reg <= {`HMTF_RST_OVT_HI, 1'b0}; // R17
      irq_mask_reg <= RST_MASK[1:0]; // R19
    end else if (REG_WR) begin
      if (!in_win || bank == 3'h0) begin
        // bank 0 and fixed indices
        case (REG_INDEX)
          `HMTF_IDX_BANK_SEL: bank_sel_reg <= REG_WDATA; // R21
          `HMTF_IDX_FAN_DIV1: fan_div1_reg <= REG_WDATA; // R22
          `HMTF_IDX_DIODE_SEL: diode_sel_reg <= REG_WDATA;
          `HMTF_IDX_BAT_CTRL: bat_ctrl_reg <= REG_WDATA;
          `HMTF_IDX_CRIT_EN: crit_en_reg <= REG_WDATA;
          `HMTF_IDX_FAN_MAX: fan_max_reg <= REG_WDATA;
          `HMTF_IDX_FAN_STEP: fan_step_reg <= REG_WDATA;
          `HMTF_IDX_SYS_CRIT: sys_crit_reg <= REG_WDATA;
          `HMTF_IDX_CPU_CRIT: cpu_crit_reg <= REG_WDATA;
          default: begin
          end
        endcase
      end else if (bank == `HMTF_BANK_CPU) begin
        // cpu channel limits and config
        case (REG_INDEX)
          `HMTF_IDX_CFG: cfg_reg <= REG_WDATA;
          `HMTF_IDX_HYST_HI: hyst_reg[8:1] <= REG_WDATA; // R16
          `HMTF_IDX_HYST_LO: hyst_reg[0] <= REG_WDATA[7];
          `HMTF_IDX_OVT_HI: ovt_reg[8:1] <= REG_WDATA; // R17
          `HMTF_IDX_OVT_LO: ovt_reg[0] <= REG_WDATA[7];
          default: begin
          end
        endcase
      end else if (bank == `HMTF_BANK_SUP &&
                   REG_INDEX == `HMTF_IDX_IRQ_MASK) begin
        irq_mask_reg <= REG_WDATA[1:0]; // R19
      end
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  // read data registered; unmapped reads return zero
  always @(posedge CORE_CLK) begin
    if (RST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      REG_RDATA <= 8'h00;
      if (!in_win || bank == 3'h0) begin
        case (REG_INDEX)
          `HMTF_IDX_BANK_SEL: REG_RDATA <= bank_sel_reg;
          `HMTF_IDX_FAN_DIV1: REG_RDATA <= fan_div1_reg;
          `HMTF_IDX_DIODE_SEL: REG_RDATA <= diode_sel_reg;
          `HMTF_IDX_BAT_CTRL: REG_RDATA <= bat_ctrl_reg;
          `HMTF_IDX_CRIT_EN: REG_RDATA <= crit_en_reg;
          `HMTF_IDX_FAN_MAX: REG_RDATA <= fan_max_reg;
          `HMTF_IDX_FAN_STEP: REG_RDATA <= fan_step_reg;
          `HMTF_IDX_SYS_CRIT: REG_RDATA <= sys_crit_reg;
          `HMTF_IDX_CPU_CRIT: REG_RDATA <= cpu_crit_reg;
          default: REG_RDATA <= 8'h00;
        endcase
      end else if (bank == `HMTF_BANK_CPU) begin
        case (REG_INDEX)
          `HMTF_IDX_TEMP_HI: REG_RDATA <= bank1_temp[8:1]; // R11
          `HMTF_IDX_TEMP_LO: REG_RDATA <= {bank1_temp[0], 7'h00};
          `HMTF_IDX_CFG: REG_RDATA <= cfg_reg;
          `HMTF_IDX_HYST_HI: REG_RDATA <= hyst_reg[8:1];
          `HMTF_IDX_HYST_LO: REG_RDATA <= {hyst_reg[0], 7'h00};
          `HMTF_IDX_OVT_HI: REG_RDATA <= ovt_reg[8:1];
          `HMTF_IDX_OVT_LO: REG_RDATA <= {ovt_reg[0], 7'h00};
          default: REG_RDATA <= 8'h00;
        endcase
      end else if (bank == `HMTF_BANK_SYS) begin
        case (REG_INDEX)
          `HMTF_IDX_TEMP_HI: REG_RDATA <= bank2_temp[8:1]; // R11
          `HMTF_IDX_TEMP_LO: REG_RDATA <= {bank2_temp[0], 7'h00};
          default: REG_RDATA <= 8'h00;
        endcase
      end else if (bank == `HMTF_BANK_SUP) begin
        case (REG_INDEX)
          `HMTF_IDX_IRQ_STS: REG_RDATA <= {6'h00, irq_sts_reg}; // R18
          `HMTF_IDX_IRQ_MASK: REG_RDATA <= {RST_MASK[7:2], irq_mask_reg};
          default: REG_RDATA <= 8'h00;
        endcase
      end
    end
  end

  // ****************************************
  // sensor configuration outputs
  // ****************************************
  // current mode wins, else type bit picks diode or thermistor
  always @(posedge CORE_CLK) begin
    if (RST) begin
      CPU_SENSE_MODE <= SENSE_CURR;
      SYS_SENSE_MODE <= SENSE_THERM;
      CPU_TACH_DIV <= 3'h1;
      SYS_TACH_DIV <= 3'h1;
    end else begin
      if (crit_en_reg[`HMTF_CPU_CURRENT]) // R6
        CPU_SENSE_MODE <= SENSE_CURR;
      else if (bat_ctrl_reg[`HMTF_CPU_SENSOR_TYPE] && // R3
               diode_sel_reg[`HMTF_CPU_DIODE_MODE]) // R1
        CPU_SENSE_MODE <= SENSE_DIODE;
      else
        CPU_SENSE_MODE <= SENSE_THERM;
      if (crit_en_reg[`HMTF_SYS_CURRENT]) // R6
        SYS_SENSE_MODE <= SENSE_CURR;
      else if (bat_ctrl_reg[`HMTF_SYS_SENSOR_TYPE] && // R3
               diode_sel_reg[`HMTF_SYS_DIODE_MODE]) // R1
        SYS_SENSE_MODE <= SENSE_DIODE;
      else
        SYS_SENSE_MODE <= SENSE_THERM;
      // divisor code = 2^code, top bit from 5Dh
      CPU_TACH_DIV <= {bat_ctrl_reg[`HMTF_CPU_DIV_TOP],
                       fan_div1_reg[7:6]}; // R2 R22
      SYS_TACH_DIV <= {bat_ctrl_reg[`HMTF_SYS_DIV_TOP],
                       fan_div1_reg[5:4]}; // R2 R22
    end
  end

  // ****************************************
  // readings, battery enable and irq status
  // ****************************************
  // readings latch per conversion; halt freezes cpu channel
  always @(posedge CORE_CLK) begin
    if (RST) begin
      cpu_temp_reg <= 9'h000;
      sys_temp_reg <= 9'h000;
      bat_en_d_reg <= 1'b0;
      bat_wait_reg <= 1'b0;
      BAT_MON_ON <= 1'b0;
      CPU_MON_ON <= 1'b1;
      irq_sts_reg <= 2'h0;
      SYSTEM_MGMT_IRQ <= 1'b0;
    end else begin
      CPU_MON_ON <= ~cfg_reg[`HMTF_CFG_HALT]; // R15
      if (CONV_DONE && !cfg_reg[`HMTF_CFG_HALT])
        cpu_temp_reg <= CPU_TEMP_IN; // R15
      if (CONV_DONE)
        sys_temp_reg <= SYS_TEMP_IN;
      // battery reading valid one monitor cycle after enable
      bat_en_d_reg <= bat_ctrl_reg[`HMTF_BAT_MON_EN];
      if (!bat_ctrl_reg[`HMTF_BAT_MON_EN]) begin
        bat_wait_reg <= 1'b0;
        BAT_MON_ON <= 1'b0;
      end else if (!bat_en_d_reg) begin
        bat_wait_reg <= 1'b1; // R4
      end else if (bat_wait_reg && CONV_DONE) begin
        bat_wait_reg <= 1'b0;
        BAT_MON_ON <= 1'b1; // R4
      end
      // status sticky; event sets, a read clears (set wins)
      irq_sts_reg <= (REG_RD && bank == `HMTF_BANK_SUP && in_win &&
                      REG_INDEX == `HMTF_IDX_IRQ_STS) ? 2'h0 :
                     irq_sts_reg;
      if (BAT_LIMIT_EVT && BAT_MON_ON)
        irq_sts_reg[`HMTF_STS_BAT] <= 1'b1; // R18
      if (SB_LIMIT_EVT)
        irq_sts_reg[`HMTF_STS_SB] <= 1'b1; // R18
      SYSTEM_MGMT_IRQ <= |(irq_sts_reg & ~irq_mask_reg); // R19 R24
    end
  end

  // ****************************************
  // over-temperature channel
  // ****************************************
  // status with hysteresis; fault count filters trips
  always @(posedge CORE_CLK) begin
    if (RST) begin
      fault_cnt_reg <= 2'h0;
      CPU_TEMP_STS <= 1'b0;
      OVERTEMP_OUT <= 1'b0;
    end else begin
      if (cpu_over)
        CPU_TEMP_STS <= 1'b1; // R23
      else if (cpu_under)
        CPU_TEMP_STS <= 1'b0; // R23
      // interrupt mode: a config read clears; a trip in that cycle wins
      if (cfg_reg[`HMTF_CFG_OVT_MODE] && REG_RD && in_win &&
          bank == `HMTF_BANK_CPU && REG_INDEX == `HMTF_IDX_CFG)
        OVERTEMP_OUT <= 1'b0; // R14
      // filter judges the reading being taken, not the stored one
      if (CONV_DONE && !cfg_reg[`HMTF_CFG_HALT]) begin
        if (!new_over)
          fault_cnt_reg <= 2'h0;
        else if (fault_cnt_reg != cfg_reg[4:3])
          fault_cnt_reg <= fault_cnt_reg + 2'h1; // R13
        if (new_over && fault_cnt_reg == cfg_reg[4:3])
          OVERTEMP_OUT <= 1'b1; // R13
        else if (!cfg_reg[`HMTF_CFG_OVT_MODE] && new_under)
          OVERTEMP_OUT <= 1'b0; // R14
      end
    end
  end

  // ****************************************
  // fan drive control
  // ****************************************
  // tick divider sets adjustment rate
  always @(posedge CORE_CLK) begin
    if (RST || adj_tick)
      adj_cnt_reg <= ADJ_CYC[15:0] - 16'h0001;
    else
      adj_cnt_reg <= adj_cnt_reg - 16'h0001;
  end

  // stepwise drive, clamp at max; critical forces full in target mode
  always @(posedge CORE_CLK) begin
    if (RST) begin
      CPU_FAN_DRIVE <= 8'h00;
      SYS_FAN_FULL <= 1'b0;
    end else begin
      SYS_FAN_FULL <= TARGET_MODE && crit_en_reg[`HMTF_SYS_CRIT_EN] &&
                      (sys_temp_reg[8:1] > sys_crit_reg); // R10
      if (TARGET_MODE && crit_en_reg[`HMTF_CPU_CRIT_EN] &&
          cpu_temp_reg[8:1] > cpu_crit_reg)
        CPU_FAN_DRIVE <= 8'hFF; // R10
      else if (AUTO3_MODE && adj_tick) begin
        if (FAN_TEMP_HOT) begin
          if (fan_sum > {1'b0, fan_max_reg})
            CPU_FAN_DRIVE <= fan_max_reg; // R7 R8
          else
            CPU_FAN_DRIVE <= fan_sum[7:0]; // R9
        end else if (CPU_FAN_DRIVE > fan_step_reg)
          CPU_FAN_DRIVE <= CPU_FAN_DRIVE - fan_step_reg; // R9
        else
          CPU_FAN_DRIVE <= 8'h00;
      end
    end
  end

endmodule

// ---- inc/hmtf_consts.vh ----
// hmtf_consts.vh: constants for the hardware-monitor thermal/fan register bank
// assumes: included by the bank module; index/data access with bank select
`ifndef HMTF_CONSTS_VH
`define HMTF_CONSTS_VH

// ****************************************
// register indices
// ****************************************
`define HMTF_IDX_BANK_SEL 7'h4E
`define HMTF_IDX_FAN_DIV1 7'h47
`define HMTF_IDX_DIODE_SEL 7'h59
`define HMTF_IDX_BAT_CTRL 7'h5D
`define HMTF_IDX_CRIT_EN 7'h5E
`define HMTF_IDX_FAN_MAX 7'h67
`define HMTF_IDX_FAN_STEP 7'h68
`define HMTF_IDX_SYS_CRIT 7'h6B
`define HMTF_IDX_CPU_CRIT 7'h6C
`define HMTF_IDX_TEMP_HI 7'h50
`define HMTF_IDX_TEMP_LO 7'h51
`define HMTF_IDX_CFG 7'h52
`define HMTF_IDX_HYST_HI 7'h53
`define HMTF_IDX_HYST_LO 7'h54
`define HMTF_IDX_OVT_HI 7'h55
`define HMTF_IDX_OVT_LO 7'h56
`define HMTF_IDX_IRQ_STS 7'h50
`define HMTF_IDX_IRQ_MASK 7'h51
`define HMTF_BANK_WIN_LO 7'h50
`define HMTF_BANK_WIN_HI 7'h5F

// ****************************************
// banks
// ****************************************
`define HMTF_BANK_CPU 3'h1
`define HMTF_BANK_SYS 3'h2
`define HMTF_BANK_SUP 3'h4

// ****************************************
// reset values
// ****************************************
`define HMTF_RST_BANK_SEL 8'h80
`define HMTF_RST_FAN_DIV1 8'h55
`define HMTF_RST_DIODE_SEL 8'h70
`define HMTF_RST_BAT_CTRL 8'h04
`define HMTF_RST_CRIT_EN 8'h04
`define HMTF_RST_FAN_MAX 8'hFF
`define HMTF_RST_FAN_STEP 8'h01
`define HMTF_RST_CRIT_TEMP 8'hFF
`define HMTF_RST_CFG 8'h00
`define HMTF_RST_HYST_HI 8'h4B
`define HMTF_RST_OVT_HI 8'h50
`define HMTF_RST_IRQ_MASK 8'h13

// ****************************************
// field positions
// ****************************************
`define HMTF_CPU_DIODE_MODE 5
`define HMTF_SYS_DIODE_MODE 4
`define HMTF_CPU_DIV_TOP 6
`define HMTF_SYS_DIV_TOP 5
`define HMTF_CPU_SENSOR_TYPE 2
`define HMTF_SYS_SENSOR_TYPE 1
`define HMTF_BAT_MON_EN 0
`define HMTF_CPU_CRIT_EN 5
`define HMTF_SYS_CRIT_EN 4
`define HMTF_CPU_CURRENT 2
`define HMTF_SYS_CURRENT 1
`define HMTF_CFG_HALT 0
`define HMTF_CFG_OVT_MODE 1
`define HMTF_STS_BAT 1
`define HMTF_STS_SB 0

// ****************************************
// timing
// ****************************************
`define HMTF_CLK_NS 10
`define HMTF_FAN_ADJ_NS 1000

`endif

// ---- sim/hmtf_regs_properties.sv ----
// hmtf_regs_properties.sv: port checker for the thermal/fan bank
// assumes: bound into hmtf_regs; RST synchronous, active high
`timescale 1ns/10ps
module hmtf_regs_props #(
  parameter ADJ_NS = 1000
) (
  // clock, reset and host port
  input wire CORE_CLK, RST, REG_WR, REG_RD,
  input wire [6:0] REG_INDEX,
  input wire [7:0] REG_WDATA, REG_RDATA,
  // converter and fan-mode inputs
  input wire [8:0] CPU_TEMP_IN, SYS_TEMP_IN,
  input wire CONV_DONE, BAT_LIMIT_EVT, SB_LIMIT_EVT,
  input wire AUTO3_MODE, TARGET_MODE, FAN_TEMP_HOT,
  input wire [2:0] CPU_SRC_SEL, SYS_SRC_SEL,
  // bank outputs
  input wire [1:0] CPU_SENSE_MODE, SYS_SENSE_MODE,
  input wire [2:0] CPU_TACH_DIV, SYS_TACH_DIV,
  input wire [7:0] CPU_FAN_DRIVE,
  input wire BAT_MON_ON, CPU_MON_ON, SYS_FAN_FULL,
  input wire OVERTEMP_OUT, CPU_TEMP_STS, SYSTEM_MGMT_IRQ
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // read data stands until the next read
  rdata_hold_a: assert property (
    !$past(REG_RD) |-> $stable(REG_RDATA)) else $error("rdata moved");
  // drive moves only in a fan control mode
  drive_mode_a: assert property (
    $changed(CPU_FAN_DRIVE) |-> $past(AUTO3_MODE) || $past(TARGET_MODE))
    else $error("drive moved outside fan mode");
  // no full drive outside target mode
  full_mode_a: assert property (
    !TARGET_MODE && !$past(TARGET_MODE) |-> !SYS_FAN_FULL)
    else $error("full drive outside target mode");
  // divisor codes follow register writes only
  div_write_a: assert property (
    $changed(CPU_TACH_DIV) || $changed(SYS_TACH_DIV)
    |-> $past(REG_WR) || $past(REG_WR, 2)) else $error("divisor moved");
  // sensing modes follow register writes only
  sense_write_a: assert property (
    $changed(CPU_SENSE_MODE) || $changed(SYS_SENSE_MODE)
    |-> $past(REG_WR) || $past(REG_WR, 2)) else $error("sense moved");
  // monitor enable follows the halt bit write
  mon_write_a: assert property (
    $changed(CPU_MON_ON) |-> $past(REG_WR) || $past(REG_WR, 2))
    else $error("monitor enable moved");
  // battery reading valid only after a conversion
  bat_conv_a: assert property (
    $rose(BAT_MON_ON) |-> $past(CONV_DONE) || $past(CONV_DONE, 2))
    else $error("battery valid without conversion");
  // overtemp trips only on a conversion
  ovt_conv_a: assert property (
    $rose(OVERTEMP_OUT) |-> $past(CONV_DONE) || $past(CONV_DONE, 2))
    else $error("overtemp without conversion");
  // channel status sets on a conversion or a limit write
  sts_conv_a: assert property (
    $rose(CPU_TEMP_STS) |-> $past(CONV_DONE) || $past(CONV_DONE, 2)
    || $past(REG_WR) || $past(REG_WR, 2)) else $error("status rose alone");
endmodule

// ---- sim/hmtf_host.sv ----
// hmtf_host.sv: host model driving the index/data register port
// assumes: strobes one cycle long, read data valid a cycle after
`timescale 1ns/10ps
module hmtf_host (
  // clock
  input wire clk,
  // index/data port
  output reg [6:0] idx,
  output reg wr,
  output reg rd,
  output reg [7:0] wdata,
  input wire [7:0] rdata
);
  reg [2:0] bank_reg = 3'h0; // bank last selected
  initial begin
    idx = 7'h00;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
  end
  // one write cycle; software guards kept here
  task put(input [6:0] i, input [7:0] d);
    reg [7:0] v;
    v = d;
    if (i == 7'h67 && v == 8'h00) v = 8'h01;
    if (bank_reg == 3'h1 && i == 7'h52) v = v & 8'h1B;
    @(posedge clk);
    idx <= i;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~v; // released data shows no stale value
    if (i == 7'h4E) bank_reg = v[2:0];
  endtask
  // one read cycle, data taken once it stands
  task get(input [6:0] i, output [7:0] d);
    @(posedge clk);
    idx <= i;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    #1 d = rdata;
  endtask
endmodule

// ---- sim/hmtf_regs_bench.sv ----
// hmtf_regs_bench.sv: self-checking bench of the thermal/fan bank
// assumes: hmtf_host on the register port, bench drives converter side
`timescale 1ns/10ps
`define CHK(g, e) chk_val(16'(g), 16'(e));
module hmtf_regs_bench;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [8:0] ctemp = 9'h000, stemp = 9'h000;
  reg cdone = 1'b0, bevt = 1'b0, sevt = 1'b0;
  reg auto3 = 1'b0, target = 1'b0, hot = 1'b0;
  reg [2:0] csel = 3'h0, ssel = 3'h0;
  wire [6:0] idx;
  wire wr, rd, bon, mon, sfull, ovt, sts, irq;
  wire [7:0] wd, rdat, drv;
  wire [1:0] cmode, smode;
  wire [2:0] cdiv, sdiv;
  int fails = 0;
  int total_checks = 0;
  reg [31:0] seed = 32'hD1EB1970;
  logic [7:0] mdl [int]; // model of register contents
  // bank, index, reset value, writable mask
  localparam logic [25:0] TBL [0:13] = '{
    {3'h0, 7'h47, 8'h55, 8'hF0}, {3'h0, 7'h59, 8'h70, 8'h30},
    {3'h0, 7'h5D, 8'h04, 8'h66}, {3'h0, 7'h5E, 8'h04, 8'h36},
    {3'h0, 7'h67, 8'hFF, 8'hFE}, {3'h0, 7'h68, 8'h01, 8'hFF},
    {3'h0, 7'h6B, 8'hFF, 8'hFF}, {3'h0, 7'h6C, 8'hFF, 8'hFF},
    {3'h1, 7'h52, 8'h00, 8'h1B}, {3'h1, 7'h53, 8'h4B, 8'hFF},
    {3'h1, 7'h54, 8'h00, 8'h80}, {3'h1, 7'h55, 8'h50, 8'hFF},
    {3'h1, 7'h56, 8'h00, 8'h80}, {3'h4, 7'h51, 8'h13, 8'h00}};
  always #5 clk = ~clk;
  hmtf_host host (.clk(clk), .idx(idx), .wr(wr), .rd(rd), .wdata(wd),
    .rdata(rdat));
  hmtf_regs #(.ADJ_NS(50)) uut (.CORE_CLK(clk), .RST(rst),
    .REG_INDEX(idx), .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wd),
    .REG_RDATA(rdat), .CPU_TEMP_IN(ctemp), .SYS_TEMP_IN(stemp),
    .CONV_DONE(cdone), .BAT_LIMIT_EVT(bevt), .SB_LIMIT_EVT(sevt),
    .AUTO3_MODE(auto3), .TARGET_MODE(target), .FAN_TEMP_HOT(hot),
    .CPU_SRC_SEL(csel), .SYS_SRC_SEL(ssel), .CPU_SENSE_MODE(cmode),
    .SYS_SENSE_MODE(smode), .CPU_TACH_DIV(cdiv), .SYS_TACH_DIV(sdiv),
    .BAT_MON_ON(bon), .CPU_MON_ON(mon), .CPU_FAN_DRIVE(drv),
    .SYS_FAN_FULL(sfull), .OVERTEMP_OUT(ovt), .CPU_TEMP_STS(sts),
    .SYSTEM_MGMT_IRQ(irq));
  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected sensing mode: current wins, then sensor type
  function automatic [1:0] mode(input cur, input typ);
    mode = cur ? 2'h2 : {1'b0, typ};
  endfunction
  task chk_val(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // banked write or read, model kept beside it
  task w(input [2:0] b, input [6:0] i, input [7:0] d);
    if (i[6:4] == 3'h5) host.put(7'h4E, {5'h10, b});
    host.put(i, d);
    mdl[{b, 1'b0, i}] = d;
  endtask
  task r(input [2:0] b, input [6:0] i, output [7:0] d);
    if (i[6:4] == 3'h5) host.put(7'h4E, {5'h10, b});
    host.get(i, d);
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one finished conversion
  task conv(input [8:0] c, input [8:0] s);
    @(posedge clk);
    ctemp <= c;
    stemp <= s;
    cdone <= 1'b1;
    @(posedge clk);
    cdone <= 1'b0;
    tick(3);
  endtask
  // limit event pulse: 0 standby supply, 1 battery
  task evt(input int k);
    @(posedge clk);
    sevt <= (k == 0);
    bevt <= (k == 1);
    @(posedge clk);
    sevt <= 1'b0;
    bevt <= 1'b0;
    tick(3);
  endtask
  initial begin
    #900000;
    fails++;
    end_of_test;
  end
  initial begin
    reg [7:0] d;
    int k, p, e, s;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    $display("test reset state");
    `CHK({cmode, smode, cdiv, sdiv, bon, mon}, 12'h825)
    `CHK({sts, ovt, irq, sfull, drv}, 12'h000)
    for (k = 0; k < 14; k++) begin
      r(TBL[k][25:23], TBL[k][22:16], d);
      `CHK(d, TBL[k][15:8])
      seed = lfsr(seed);
      e = (seed[7:0] & TBL[k][7:0]) | (TBL[k][15:8] & ~TBL[k][7:0]);
      w(TBL[k][25:23], TBL[k][22:16], e[7:0]);
    end
    $display("test random write and read back");
    for (k = 0; k < 14; k++) begin
      r(TBL[k][25:23], TBL[k][22:16], d);
      `CHK(d, mdl[{TBL[k][25:23], 1'b0, TBL[k][22:16]}])
    end
    `CHK(cdiv, {mdl['h5D][6], mdl['h47][7:6]})
    `CHK(sdiv, {mdl['h5D][5], mdl['h47][5:4]})
    `CHK(cmode, mode(mdl['h5E][2], mdl['h5D][2] & mdl['h59][5]))
    `CHK(smode, mode(mdl['h5E][1], mdl['h5D][1] & mdl['h59][4]))
    `CHK(mon, !mdl['h152][0])
    for (k = 0; k < 14; k++) w(TBL[k][25:23], TBL[k][22:16], TBL[k][15:8]);
    $display("test unmapped and read-only places");
    w(0, 7'h5A, 8'hFF);
    r(0, 7'h5A, d);
    `CHK(d, 8'h00)
    r(0, 7'h50, d);
    `CHK(d, 8'h00)
    for (k = 0; k < 2; k++) begin
      seed = lfsr(seed);
      @(posedge clk);
      ssel <= k[2:0];
      conv(seed[8:0], seed[24:16]);
      w(1, 7'h50, 8'hFF);
      r(1, 7'h50, d);
      `CHK(d, seed[8:1])
      r(1, 7'h51, d);
      `CHK(d, {seed[0], 7'h00})
      r(2, 7'h50, d);
      `CHK(d, k ? seed[8:1] : seed[24:17])
    end
    $display("test overtemp and status");
    conv(9'h000, 9'h000); // cold reading clears trips left by random data
    w(1, 7'h52, 8'h08);
    conv(9'h0A1, 9'h000);
    `CHK({sts, ovt}, 2'h2)
    conv(9'h0A1, 9'h000);
    r(1, 7'h52, d);
    `CHK({sts, ovt}, 2'h3)
    conv(9'h097, 9'h000);
    `CHK(sts, 1'b1)
    conv(9'h095, 9'h000);
    `CHK(sts, 1'b0)
    w(1, 7'h52, 8'h0A);
    conv(9'h0A1, 9'h000);
    conv(9'h0A1, 9'h000);
    `CHK(ovt, 1'b1)
    r(1, 7'h52, d);
    tick(2);
    `CHK(ovt, 1'b0)
    $display("test battery monitor and interrupt");
    w(0, 7'h5D, 8'h05);
    tick(3);
    `CHK(bon, 1'b0)
    conv(9'h095, 9'h000);
    `CHK(bon, 1'b1)
    for (k = 0; k < 2; k++) begin
      w(4, 7'h51, 8'h13);
      evt(k);
      `CHK(irq, 1'b0)
      r(4, 7'h50, d);
      `CHK(d, 8'h01 << k)
      w(4, 7'h51, 8'h13 ^ (8'h01 << k));
      evt(k);
      `CHK(irq, 1'b1)
      r(4, 7'h50, d);
      tick(3);
      `CHK(irq, 1'b0)
    end
    $display("test stepwise fan drive");
    w(0, 7'h67, 8'h12);
    e = 0;
    for (p = 0; p < 2; p++) begin
      s = p ? 6 : 4;
      w(0, 7'h68, s[7:0]);
      @(posedge clk);
      auto3 <= 1'b1;
      hot <= (p == 0);
      for (k = 0; k < 400; k++) begin
        tick(1);
        if (drv !== e[7:0]) begin
          e = p ? ((e < s) ? 0 : e - s) : ((e + s > 18) ? 18 : e + s);
          `CHK(drv, e[7:0])
        end
      end
      `CHK(drv, p ? 8'h00 : 8'h12)
    end
    $display("test critical temperature");
    @(posedge clk);
    auto3 <= 1'b0;
    target <= 1'b1;
    w(0, 7'h6B, 8'h50);
    w(0, 7'h6C, 8'h50);
    conv(9'h0C8, 9'h0C8);
    `CHK({sfull, drv}, 9'h000)
    w(0, 7'h5E, 8'h34);
    conv(9'h0C8, 9'h0C8);
    `CHK({sfull, drv}, 9'h1FF)
    conv(9'h080, 9'h080);
    `CHK(sfull, 1'b0)
    $display("test halted channel");
    w(1, 7'h52, 8'h01);
    tick(2);
    `CHK(mon, 1'b0)
    conv(9'h0C0, 9'h000);
    r(1, 7'h50, d);
    `CHK(d, 8'h40)
    end_of_test;
  end
endmodule
bind hmtf_regs hmtf_regs_props #(.ADJ_NS(ADJ_NS)) props (.*);
